// ==== bench/net_request_processor_tb.sv ====
`timescale 1ns/1ns
module net_request_processor_tb;
  import nrp_pkg::*;
  typedef struct packed {
    logic [31:0] tag;
    logic [7:0] code;
    logic [7:0] status;
    logic [31:0] arg;
    logic chk_arg;
  } nrp_note_type;
  logic clk = 0, rst = 1, host_doorbell = 0, front_end_mode = 0, controller_mode = 0;
  logic off_net = 0, net_disable = 0, req_valid = 0, rpl_ready = 1, rx_pkt = 0;
  logic slow = 0, loop_pass = 0, loop_mcast = 0, imperfect_filter = 0;
  logic [7:0] send_status = 8'h00;
  nrp_req_type req_data = '0;
  logic req_ready, rpl_valid, start_exec, mgmt_valid, blk_fetch, blk_done, tx_start, tx_done;
  logic tx_filter_pass, tx_multicast;
  logic [31:0] rpl_tag, rpl_arg, start_pc;
  logic [7:0] rpl_code, rpl_status, mgmt_code, tx_status;
  logic [2:0] blk_idx;
  int errors = 0, check_count = 0, cycles = 0, tx_seen = 0, blk_exp = 0;
  nrp_note_type notes[$];
  logic [31:0] starts[$], mgmts[$];
  nrp_note_type got;

  always #4 clk = ~clk;

  nrp_request_processor uut (.clk(clk), .rst(rst), .host_doorbell(host_doorbell),
    .front_end_mode(front_end_mode), .controller_mode(controller_mode), .off_net(off_net),
    .net_disable(net_disable), .imperfect_filter(imperfect_filter), .req_valid(req_valid),
    .req_data(req_data), .req_ready(req_ready), .rpl_valid(rpl_valid), .rpl_ready(rpl_ready),
    .rpl_tag(rpl_tag), .rpl_code(rpl_code), .rpl_status(rpl_status), .rpl_arg(rpl_arg),
    .start_exec(start_exec), .start_pc(start_pc), .mgmt_valid(mgmt_valid),
    .mgmt_code(mgmt_code), .blk_fetch(blk_fetch), .blk_idx(blk_idx), .blk_done(blk_done),
    .tx_start(tx_start), .tx_done(tx_done), .tx_status(tx_status),
    .tx_filter_pass(tx_filter_pass), .tx_multicast(tx_multicast), .rx_pkt(rx_pkt));

  nrp_link_model link (.clk(clk), .rst(rst), .slow(slow), .loop_pass(loop_pass),
    .loop_mcast(loop_mcast),
    .send_status(send_status), .blk_fetch(blk_fetch), .tx_start(tx_start),
    .blk_done(blk_done), .tx_done(tx_done), .tx_status(tx_status),
    .tx_filter_pass(tx_filter_pass), .tx_multicast(tx_multicast));

  task automatic close_out;
    $display("Comparisons %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] seen);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Offers one request; the note goes before the last one when jump is set
  task automatic send(input logic [7:0] code, input logic [31:0] arg, input logic [3:0] nblk,
                      input logic [7:0] len, input logic [7:0] st, input bit jump,
                      output bit taken);
    nrp_note_type n;
    int i;
    n = '{tag: $urandom, code: code, status: st, arg: arg, chk_arg: code == CODE_START};
    @(posedge clk);
    #1;
    req_data = '{tag: n.tag, code: code, arg: arg, nblk: nblk, len: len};
    req_valid = 1;
    host_doorbell = 1;
    taken = 0;
    for (i = 0; i < 40 && !taken; i++) begin
      @(posedge clk);
      taken = req_ready;
      if (taken && jump && notes.size() > 0) begin
        notes.insert(notes.size() - 1, n);
      end else if (taken) begin
        notes.push_back(n);
      end
      if (taken && st == RC_OK && code == CODE_START) starts.push_back(arg);
      if (taken && st == RC_OK && code inside {CODE_NET_MODE, CODE_ADDR_SLOT, CODE_STATS}) begin
        mgmts.push_back({24'h000000, code});
      end
      #1 host_doorbell = 0;
    end
    req_valid = 0;
  endtask

  task automatic wait_idle;
    for (int i = 0; i < 3000 && notes.size() != 0; i++) begin
      @(posedge clk);
    end
    #1;
    check_val("pending", 0, notes.size());
    check_val("events", 0, starts.size() + mgmts.size());
  endtask

  task automatic settle;
    repeat (8) @(posedge clk);
    #1;
  endtask

  always @(posedge clk) begin
    if (!rst && rpl_valid && rpl_ready) begin
      if (notes.size() == 0) begin
        errors++;
        $display("Error reply expected none seen %h", rpl_tag);
      end else begin
        got = notes.pop_front();
        check_val("tag", got.tag, rpl_tag);
        check_val("code", got.code, rpl_code);
        check_val("status", got.status, rpl_status);
        if (got.chk_arg) check_val("arg", got.arg, rpl_arg);
      end
    end
    if (!rst && start_exec) begin
      check_val("start_pc", starts.size() ? starts.pop_front() : 'x, start_pc);
    end
    if (!rst && mgmt_valid) begin
      check_val("mgmt_code", mgmts.size() ? mgmts.pop_front() : 'x, mgmt_code);
    end
    if (!rst && blk_fetch && blk_done) begin
      check_val("blk_idx", blk_exp, blk_idx);
      blk_exp++;
    end else if (!blk_fetch) begin
      blk_exp = 0;
    end
    if (tx_start) tx_seen++;
    cycles++;
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end

  always @(posedge clk) #1 rpl_ready = ($urandom_range(0, 3) != 0);

  initial begin
    bit tk;
    int k;
    void'($urandom(12218));
    repeat (2) @(posedge clk);
    #1 rst = 0;
    front_end_mode = 1;
    settle();
    send(CODE_START, 32'h12003400, 4'h0, MIN_LEN_START, RC_OK, 0, tk);
    send(CODE_START, {MAX_ENTRY_SEG, 24'h000010}, 4'h0, MIN_LEN_START, RC_OK, 0, tk);
    send(CODE_START, 32'h80000010, 4'h0, MIN_LEN_START, RC_BAD_ADDR, 0, tk);
    send(CODE_START, 32'h00000010, 4'h0, 8'h0B, RC_GEN_ERR, 0, tk);
    wait_idle();
    check_val("start_pc", {MAX_ENTRY_SEG, 24'h000010}, start_pc);
    front_end_mode = 0;
    settle();
    send(CODE_START, 32'h00000010, 4'h0, MIN_LEN_START, RC_GEN_ERR, 0, tk);
    send(CODE_NET_MODE, 32'h0, 4'h1, MIN_LEN_MGMT, RC_GEN_ERR, 0, tk);
    controller_mode = 1;
    settle();
    send(CODE_NET_MODE, $urandom, 4'h1, MIN_LEN_MGMT, RC_OK, 0, tk);
    send(CODE_ADDR_SLOT, $urandom, 4'h1, MIN_LEN_MGMT, RC_OK, 0, tk);
    send(CODE_STATS, $urandom, 4'h1, MIN_LEN_MGMT, RC_OK, 0, tk);
    send(CODE_STATS, $urandom, 4'h1, 8'h07, RC_GEN_ERR, 0, tk);
    send(8'h55, $urandom, 4'h1, MIN_LEN_XFER, RC_GEN_ERR, 0, tk);
    send_status = 8'($urandom_range(0, 2));
    send(CODE_TX, $urandom, MAX_BLOCKS, MIN_LEN_XFER, send_status, 0, tk);
    send(CODE_TX, $urandom, 4'h9, MIN_LEN_XFER, RC_GEN_ERR, 1, tk);
    wait_idle();
    net_disable = 1;
    settle();
    k = tx_seen;
    send(CODE_TX, $urandom, 4'h2, MIN_LEN_XFER, RC_OK, 0, tk);
    wait_idle();
    check_val("sends", k, tx_seen);
    net_disable = 0;
    rx_pkt = 1;
    @(posedge clk);
    #1 rx_pkt = 0;
    send(CODE_RX, $urandom, 4'h1, MIN_LEN_XFER, RC_OK, 0, tk);
    wait_idle();
    send(CODE_RX, $urandom, 4'h1, MIN_LEN_XFER, RC_OK, 0, tk);
    send(CODE_ADDR_SLOT, $urandom, 4'h1, MIN_LEN_MGMT, RC_OK, 1, tk);
    loop_pass = 1;
    send(CODE_TX_SELF, $urandom, 4'h2, MIN_LEN_XFER, send_status, 1, tk);
    wait_idle();
    loop_pass = 0;
    imperfect_filter = 1;
    loop_mcast = 1;
    settle();
    send(CODE_RX, $urandom, 4'h1, MIN_LEN_XFER, RC_OK, 0, tk);
    send(CODE_TX_SELF, $urandom, 4'h1, MIN_LEN_XFER, send_status, 1, tk);
    wait_idle();
    imperfect_filter = 0;
    loop_mcast = 0;
    off_net = 1;
    slow = 1;
    settle();
    k = tx_seen;
    for (int i = 0; i < MAX_OUTSTANDING; i++) begin
      send(CODE_TX, $urandom, 4'h1, MIN_LEN_XFER, send_status, 0, tk);
    end
    check_val("taken", 1, tk);
    send(CODE_TX, $urandom, 4'h1, MIN_LEN_XFER, send_status, 0, tk);
    check_val("refused", 0, tk);
    check_val("sends", k, tx_seen);
    off_net = 0;
    wait_idle();
    send(CODE_TX, $urandom, 4'h3, MIN_LEN_XFER, send_status, 0, tk);
    check_val("taken", 1, tk);
    wait_idle();
    close_out();
  end
endmodule // net_request_processor_tb

// ==== bench/nrp_link_model.sv ====
`timescale 1ns/1ns
module nrp_link_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic loop_pass,
  input wire logic loop_mcast,
  input wire logic [7:0] send_status,
  input wire logic blk_fetch,
  input wire logic tx_start,
  output logic blk_done,
  output logic tx_done,
  output logic [7:0] tx_status,
  output logic tx_filter_pass,
  output logic tx_multicast
);
  logic [3:0] blk_cnt_q;
  logic [3:0] tx_cnt_q;
  logic tx_busy_q;
  wire [3:0] wait_len = slow ? 4'h6 : 4'h2;
  // Each block copy ends after a short or long memory delay
  always_ff @(posedge clk) begin
    blk_done <= 1'b0;
    if (rst || !blk_fetch || blk_done) begin
      blk_cnt_q <= 4'h0;
    end else if (blk_cnt_q == wait_len) begin
      blk_done <= 1'b1;
    end else begin
      blk_cnt_q <= blk_cnt_q + 4'h1;
    end
  end
  // Link adds framing itself; a started send always runs to its end
  always_ff @(posedge clk) begin
    tx_done <= 1'b0;
    if (rst) begin
      tx_busy_q <= 1'b0;
      tx_cnt_q <= 4'h0;
    end else if (tx_start) begin
      tx_busy_q <= 1'b1;
      tx_cnt_q <= 4'h0;
    end else if (tx_busy_q && tx_cnt_q == wait_len) begin
      tx_done <= 1'b1;
      tx_busy_q <= 1'b0;
    end else begin
      tx_cnt_q <= tx_cnt_q + 4'h1;
    end
  end
  // Results only hold with the done pulse
  assign tx_status = tx_done ? send_status : ~send_status;
  assign tx_filter_pass = tx_done ? loop_pass : ~loop_pass;
  assign tx_multicast = tx_done ? loop_mcast : ~loop_mcast;
endmodule // nrp_link_model

// ==== src/nrp_fifo.sv ====
`timescale 1ns/1ns
module nrp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  nrp_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic out_valid_q;
  logic [WIDTH-1:0] out_data_q;
  wire push = f.in_valid && f.in_ready;
  wire refill = (cnt_q != '0) && (!out_valid_q || f.out_ready);
  wire drop = out_valid_q && f.out_ready && !refill;

  assign f.in_ready = (cnt_q != DEPTH[AW:0]);
  assign f.out_valid = out_valid_q;
  assign f.out_data = out_data_q;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= f.in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end else begin
      wr_q <= push ? wr_q + 1'b1 : wr_q;
      rd_q <= refill ? rd_q + 1'b1 : rd_q;
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, refill};
      out_valid_q <= refill ? 1'b1 : (drop ? 1'b0 : out_valid_q);
      out_data_q <= refill ? mem_q[rd_q] : out_data_q;
    end
  end
endmodule // nrp_fifo

// ==== src/nrp_fifo_if.sv ====
`timescale 1ns/1ns
interface nrp_fifo_if #(parameter int WIDTH = 8);
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;
  modport producer(output in_valid, output in_data, input in_ready,
                   input out_valid, input out_data, output out_ready);
  modport fifo(input in_valid, input in_data, output in_ready,
               output out_valid, output out_data, input out_ready);
endinterface

// ==== src/nrp_pkg.sv ====
package nrp_pkg;
  // Message byte offsets
  localparam int OFF_RESERVED = 0;
  localparam int OFF_TAG = 2;
  localparam int OFF_CODE = 6;
  localparam int OFF_STATUS = 7;
  localparam int OFF_ARG = 8;
  // Request codes
  localparam logic [7:0] CODE_START = 8'h02;
  localparam logic [7:0] CODE_NET_MODE = 8'h08;
  localparam logic [7:0] CODE_ADDR_SLOT = 8'h09;
  localparam logic [7:0] CODE_STATS = 8'h0A;
  localparam logic [7:0] CODE_TX = 8'h0C;
  localparam logic [7:0] CODE_RX = 8'h0D;
  localparam logic [7:0] CODE_TX_SELF = 8'h0E;
  // Return codes
  localparam logic [7:0] RC_OK = 8'h00;
  localparam logic [7:0] RC_BAD_ADDR = 8'hA2;
  localparam logic [7:0] RC_GEN_ERR = 8'hA1;
  // Least message lengths in bytes
  localparam logic [7:0] MIN_LEN_START = 8'h0C;
  localparam logic [7:0] MIN_LEN_MGMT = 8'h08;
  localparam logic [7:0] MIN_LEN_XFER = 8'h10;
  // Highest segment accepted for an entry address
  localparam logic [7:0] MAX_ENTRY_SEG = 8'h7F;
  // Capacities
  localparam int MAX_OUTSTANDING = 32;
  localparam logic [6:0] MAX_OUT_CNT = 7'h20;
  localparam int TX_BUFS = 4;
  localparam logic [2:0] TX_BUFS_CNT = 3'h4;
  localparam logic [3:0] MAX_BLOCKS = 4'h8;
  localparam int RXQ_DEPTH = 8;
  localparam logic [3:0] RXQ_CNT_MAX = 4'h8;
  localparam logic [5:0] RX_PKT_MAX = 6'h20;
  localparam int SYNC_W = 6;

  typedef struct packed {
    logic [31:0] tag;
    logic [7:0] code;
    logic [31:0] arg;
    logic [3:0] nblk;
    logic [7:0] len;
  } nrp_req_type;

  localparam int REQ_W = $bits(nrp_req_type);

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_GATHER = 3'b001,
    TX_WAIT = 3'b010,
    TX_SEND = 3'b011,
    TX_REPLY = 3'b100
  } nrp_tx_state_type;
endpackage

// ==== src/nrp_request_processor.sv ====
// Notes on behaviour
// R1: Reserved leading two bytes are ignored on entry and not returned.
// R2: Requester tag is never interpreted and comes back unchanged in the reply.
// R3: Start-execution code 02H is kept unchanged in its reply.
// R4: Start-execution returns 0, A2H for bad entry, A1H outside front-end mode.
// R5: Entry address field is echoed unchanged in the reply.
// R6: Host selects controller mode with mode 0 and downloads nothing.
// R7: Controller mode accepts transmit, receive, net mode, address slot, statistics.
// R8: Host doorbell lets the device pull queued requests into its buffer.
// R9: At most 32 outstanding requests; further ones wait in the host queue.
// R10: Host keeps no more than 32 receive requests pending.
// R11: Filtered packets are buffered even with no receive request waiting.
// R12: Per-type queues; management immediate, transmit at link pace, receive needs packet.
// R13: Each reply is posted on completion, so replies may come out of order.
// R14: Host waits for each reply when cross-type order matters.
// R15: Short message, unknown code or wrong mode answers with A1H.
// R16: Device adds preamble and frame check; host supplies addresses and type.
// R17: A transmit packet is gathered from up to eight host blocks.
// R18: Four transmit buffers; fetching stalls while all four are taken.
// R19: Off network, transmits wait; one already sending finishes first.
// R20: With network disable, transmits complete normally but nothing is sent.
// R21: Code 0EH loops a filtered packet back; imperfect filtering loops multicast.
// R22: Transmits run in arrival order; the packet stays device-owned until reply.
`timescale 1ns/1ns
module nrp_request_processor
  import nrp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic host_doorbell,
  input wire logic front_end_mode,
  input wire logic controller_mode,
  input wire logic off_net,
  input wire logic net_disable,
  input wire logic imperfect_filter,
  input wire logic req_valid,
  input wire nrp_req_type req_data,
  output logic req_ready,
  output logic rpl_valid,
  input wire logic rpl_ready,
  output logic [31:0] rpl_tag,
  output logic [7:0] rpl_code,
  output logic [7:0] rpl_status,
  output logic [31:0] rpl_arg,
  output logic start_exec,
  output logic [31:0] start_pc,
  output logic mgmt_valid,
  output logic [7:0] mgmt_code,
  output logic blk_fetch,
  output logic [2:0] blk_idx,
  input wire logic blk_done,
  output logic tx_start,
  input wire logic tx_done,
  input wire logic [7:0] tx_status,
  input wire logic tx_filter_pass,
  input wire logic tx_multicast,
  input wire logic rx_pkt
);
  // Pin synchronisers
  logic [SYNC_W-1:0] pin_meta_q;
  logic [SYNC_W-1:0] pin_q;
  logic bell_prev_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_meta_q <= '0;
      pin_q <= '0;
      bell_prev_q <= 1'b0;
    end else begin
      pin_meta_q <= {host_doorbell, front_end_mode, controller_mode, off_net, net_disable,
                     imperfect_filter};
      pin_q <= pin_meta_q;
      bell_prev_q <= pin_q[5];
    end
  end
  wire bell_rise = pin_q[5] && !bell_prev_q;
  wire fe_mode_s = pin_q[4];
  wire ctrl_mode_s = pin_q[3];
  wire off_net_s = pin_q[2];
  wire net_dis_s = pin_q[1];
  wire imperfect_s = pin_q[0];

  // Request intake
  nrp_fifo_if #(.WIDTH(REQ_W)) rq ();
  nrp_fifo #(.WIDTH(REQ_W), .DEPTH(MAX_OUTSTANDING)) u_fifo (
    .clk(clk),
    .rst(rst),
    .f(rq)
  );
  logic bell_q;
  logic req_ready_q;
  logic [6:0] out_cnt_q;
  wire accept = req_valid && req_ready_q;
  wire rpl_fire = rpl_valid && rpl_ready;
  wire [6:0] out_cnt_d = out_cnt_q + {6'h00, accept} - {6'h00, rpl_fire};
  wire bell_d = bell_rise || (bell_q && req_valid); // see R8
  assign rq.in_valid = accept;
  assign rq.in_data = req_data;
  always_ff @(posedge clk) begin
    if (rst) begin
      bell_q <= 1'b0;
      req_ready_q <= 1'b0;
      out_cnt_q <= '0;
    end else begin
      bell_q <= bell_d;
      out_cnt_q <= out_cnt_d;
      req_ready_q <= bell_d && (out_cnt_d < MAX_OUT_CNT) && rq.in_ready; // see R9
    end
  end
  assign req_ready = req_ready_q;

  // Dispatch decode; reserved bytes never reach this point, see R1
  nrp_req_type hd;
  assign hd = rq.out_data;
  wire is_start = (hd.code == CODE_START);
  wire is_tx = (hd.code == CODE_TX) || (hd.code == CODE_TX_SELF);
  wire is_rx = (hd.code == CODE_RX);
  wire is_mgmt = (hd.code == CODE_NET_MODE) || (hd.code == CODE_ADDR_SLOT) ||
                 (hd.code == CODE_STATS);
  wire blk_bad = (hd.nblk == 4'h0) || (hd.nblk > MAX_BLOCKS); // see R17
  wire ctrl_short = is_mgmt ? (hd.len < MIN_LEN_MGMT) : ((hd.len < MIN_LEN_XFER) || blk_bad);
  wire ctrl_ok = ctrl_mode_s && (is_tx || is_rx || is_mgmt) && !ctrl_short; // see R7
  wire start_fe_ok = fe_mode_s && (hd.len >= MIN_LEN_START);
  wire entry_ok = (hd.arg[31:24] <= MAX_ENTRY_SEG);
  wire gen_err = is_start ? !start_fe_ok : !ctrl_ok; // see R15
  wire to_tx = !gen_err && is_tx;
  wire to_rx = !gen_err && is_rx;
  wire to_imm = !to_tx && !to_rx;

  logic imm_valid_q;
  nrp_req_type imm_q;
  logic [7:0] imm_status_q;
  logic [2:0] tq_cnt;
  logic [3:0] rq_cnt;
  wire pop = rq.out_valid && ((to_imm && !imm_valid_q) || (to_tx && tq_cnt < TX_BUFS_CNT) ||
                              (to_rx && rq_cnt < RXQ_CNT_MAX)); // see R12
  assign rq.out_ready = pop;
  wire [7:0] imm_status_d = gen_err ? RC_GEN_ERR : (is_start && !entry_ok) ? RC_BAD_ADDR :
                            RC_OK; // see R4

  // Reply arbitration: fixed priority, immediate results first, then transmit, then receive
  nrp_tx_state_type tx_st;
  logic [5:0] rxb_cnt;
  wire sel_imm = imm_valid_q;
  wire sel_tx = !sel_imm && (tx_st == TX_REPLY);
  wire sel_rx = !sel_imm && !sel_tx && (rq_cnt != 4'h0) && (rxb_cnt != 6'h00); // see R12
  wire rpl_load = (!rpl_valid || rpl_ready) && (sel_imm || sel_tx || sel_rx); // see R13
  wire take_imm = rpl_load && sel_imm;
  wire take_tx = rpl_load && sel_tx;
  wire take_rx = rpl_load && sel_rx;

  always_ff @(posedge clk) begin
    if (rst) begin
      imm_valid_q <= 1'b0;
      imm_q <= '0;
      imm_status_q <= RC_OK;
      start_exec <= 1'b0;
      start_pc <= '0;
      mgmt_valid <= 1'b0;
      mgmt_code <= '0;
    end else begin
      imm_valid_q <= (pop && to_imm) || (imm_valid_q && !take_imm);
      imm_q <= (pop && to_imm) ? hd : imm_q;
      imm_status_q <= (pop && to_imm) ? imm_status_d : imm_status_q;
      start_exec <= pop && is_start && imm_status_d == RC_OK; // see R4
      start_pc <= (pop && is_start && imm_status_d == RC_OK) ? hd.arg : start_pc;
      mgmt_valid <= pop && to_imm && is_mgmt && !gen_err; // see R12
      mgmt_code <= (pop && is_mgmt) ? hd.code : mgmt_code;
    end
  end

  // Transmit slots, served in arrival order
  nrp_req_type tq_q [TX_BUFS];
  logic [1:0] tq_wr_q;
  logic [1:0] tq_rd_q;
  logic [2:0] tq_cnt_q;
  logic [7:0] tx_stat_q;
  logic [3:0] blk_q;
  wire tq_push = pop && to_tx;
  assign tq_cnt = tq_cnt_q;
  nrp_req_type tx_cur;
  assign tx_cur = tq_q[tq_rd_q];
  wire self_loop = (tx_cur.code == CODE_TX_SELF) &&
                   (tx_filter_pass || (imperfect_s && tx_multicast)); // see R21
  always_ff @(posedge clk) begin
    if (tq_push) begin
      tq_q[tq_wr_q] <= hd;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      tq_wr_q <= '0;
      tq_rd_q <= '0;
      tq_cnt_q <= '0;
    end else begin
      tq_wr_q <= tq_push ? tq_wr_q + 2'h1 : tq_wr_q;
      tq_rd_q <= take_tx ? tq_rd_q + 2'h1 : tq_rd_q; // see R22
      tq_cnt_q <= tq_cnt_q + {2'h0, tq_push} - {2'h0, take_tx}; // see R18
    end
  end

  // Transmit engine: gather blocks, wait for the net, send
  logic loop_pkt_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_st <= TX_IDLE;
      blk_q <= '0;
      blk_fetch <= 1'b0;
      tx_start <= 1'b0;
      tx_stat_q <= RC_OK;
      loop_pkt_q <= 1'b0;
    end else begin
      tx_start <= 1'b0;
      loop_pkt_q <= 1'b0;
      case (tx_st)
        TX_IDLE: begin
          if (tq_cnt_q != 3'h0) begin
            tx_st <= TX_GATHER;
            blk_q <= '0;
            blk_fetch <= 1'b1; // see R17
          end
        end
        TX_GATHER: begin
          if (blk_done) begin
            if (blk_q + 4'h1 == tx_cur.nblk) begin
              blk_fetch <= 1'b0;
              tx_st <= TX_WAIT;
            end else begin
              blk_q <= blk_q + 4'h1;
            end
          end
        end
        TX_WAIT: begin
          if (!off_net_s) begin // see R19
            if (net_dis_s) begin
              tx_stat_q <= RC_OK; // see R20
              tx_st <= TX_REPLY;
            end else begin
              tx_start <= 1'b1; // see R16
              tx_st <= TX_SEND;
            end
          end
        end
        TX_SEND: begin
          if (tx_done) begin // see R19
            tx_stat_q <= tx_status;
            loop_pkt_q <= self_loop; // see R21
            tx_st <= TX_REPLY;
          end
        end
        TX_REPLY: begin
          if (take_tx) begin
            tx_st <= TX_IDLE;
          end
        end
        default: begin
          tx_st <= TX_IDLE;
        end
      endcase
    end
  end
  assign blk_idx = blk_q[2:0];

  // Receive requests wait for buffered packets
  nrp_req_type rxq_q [RXQ_DEPTH];
  logic [2:0] rx_wr_q;
  logic [2:0] rx_rd_q;
  logic [3:0] rq_cnt_q;
  wire rx_push = pop && to_rx;
  assign rq_cnt = rq_cnt_q;
  wire pkt_in = rx_pkt || loop_pkt_q;
  wire pkt_room = (rxb_cnt != RX_PKT_MAX);
  always_ff @(posedge clk) begin
    if (rx_push) begin
      rxq_q[rx_wr_q] <= hd;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_wr_q <= '0;
      rx_rd_q <= '0;
      rq_cnt_q <= '0;
      rxb_cnt <= '0;
    end else begin
      rx_wr_q <= rx_push ? rx_wr_q + 3'h1 : rx_wr_q;
      rx_rd_q <= take_rx ? rx_rd_q + 3'h1 : rx_rd_q;
      rq_cnt_q <= rq_cnt_q + {3'h0, rx_push} - {3'h0, take_rx};
      rxb_cnt <= rxb_cnt + {5'h00, pkt_in && pkt_room} - {5'h00, take_rx}; // see R11
    end
  end

  // Reply register
  nrp_req_type rsrc;
  assign rsrc = sel_imm ? imm_q : sel_tx ? tx_cur : rxq_q[rx_rd_q];
  wire [7:0] rstat = sel_imm ? imm_status_q : sel_tx ? tx_stat_q : RC_OK;
  always_ff @(posedge clk) begin
    if (rst) begin
      rpl_valid <= 1'b0;
      rpl_tag <= '0;
      rpl_code <= '0;
      rpl_status <= RC_OK;
      rpl_arg <= '0;
    end else begin
      rpl_valid <= rpl_load || (rpl_valid && !rpl_ready);
      rpl_tag <= rpl_load ? rsrc.tag : rpl_tag; // see R2
      rpl_code <= rpl_load ? rsrc.code : rpl_code; // see R3
      rpl_status <= rpl_load ? rstat : rpl_status;
      rpl_arg <= rpl_load ? rsrc.arg : rpl_arg; // see R5
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  out_limit_a: assert property (accept |-> out_cnt_q < MAX_OUT_CNT) // see R9
    else $error("more than 32 requests outstanding");
  tag_echo_a: assert property (take_imm |=> rpl_valid && rpl_tag == $past(imm_q.tag)) // see R2
    else $error("reply tag differs from request tag");
  start_code_a: assert property (take_imm && imm_q.code == CODE_START |=> // see R3
    rpl_code == CODE_START && rpl_arg == $past(imm_q.arg)) else $error("start reply altered");
  gen_err_a: assert property (pop && gen_err |=> imm_valid_q && imm_status_q == RC_GEN_ERR) // see R15
    else $error("general error not reported");
  bad_entry_a: assert property (pop && is_start && start_fe_ok && !entry_ok |=> // see R4
    imm_status_q == RC_BAD_ADDR && !start_exec) else $error("bad entry not refused");
  off_hold_a: assert property (tx_st == TX_WAIT && off_net_s |=> // see R19
    tx_st == TX_WAIT && !tx_start) else $error("transmit while off network");
  net_dis_a: assert property (tx_st == TX_WAIT && !off_net_s && net_dis_s |=> // see R20
    tx_st == TX_REPLY && !tx_start && tx_stat_q == RC_OK) else $error("disabled net sent");
  blk_limit_a: assert property (blk_fetch |-> blk_q < {1'b0, tx_cur.nblk[2:0]} ||
    tx_cur.nblk == MAX_BLOCKS) // see R17
    else $error("block index beyond count");
  tx_slots_a: assert property (tq_push |-> tq_cnt_q < TX_BUFS_CNT) // see R18
    else $error("fifth transmit buffer used");
  rx_wait_a: assert property (take_rx |-> rxb_cnt != 6'h00 ##1 rpl_status == RC_OK) // see R12
    else $error("receive completed without packet");
endmodule // nrp_request_processor
